/* src/drv_pkg.sv */
// shared constants, parameter map and helper functions of the drive control block
package drv_pkg;
  localparam int DW = 16;
  localparam int IW = 7;
  localparam int NUM_PARAM = 100;
  // parameter indices; byte address is four times the index
  localparam logic [IW-1:0] P_MAIN = 7'h00;
  localparam logic [IW-1:0] P_ACC = 7'h01;
  localparam logic [IW-1:0] P_DEC = 7'h02;
  localparam logic [IW-1:0] P_BRK_FREQ = 7'h05;
  localparam logic [IW-1:0] P_BRK_VOLT = 7'h06;
  localparam logic [IW-1:0] P_BRK_TIME = 7'h07;
  localparam logic [IW-1:0] P_BRK_DLY = 7'h08;
  localparam logic [IW-1:0] P_MAXC = 7'h0c;
  localparam logic [IW-1:0] P_MINC = 7'h0d;
  localparam logic [IW-1:0] P_TRANS = 7'h0e;
  localparam logic [IW-1:0] P_UPPER = 7'h0f;
  localparam logic [IW-1:0] P_LOWER = 7'h10;
  localparam logic [IW-1:0] P_SKIP = 7'h11;
  localparam logic [IW-1:0] P_BAND = 7'h12;
  localparam logic [IW-1:0] P_JOG = 7'h13;
  localparam logic [IW-1:0] P_JOG_RATE = 7'h14;
  localparam logic [IW-1:0] P_PRESET_SPEED_ONE = 7'h15;
  localparam logic [IW-1:0] P_SPD2 = 7'h18;
  localparam logic [IW-1:0] P_SPD3 = 7'h1b;
  localparam logic [IW-1:0] P_COAST = 7'h1e;
  localparam logic [IW-1:0] P_REV = 7'h1f;
  localparam logic [IW-1:0] P_DISCH = 7'h21;
  localparam logic [IW-1:0] P_RESTART = 7'h22;
  localparam logic [IW-1:0] P_BLANK = 7'h24;
  localparam logic [IW-1:0] P_SRC = 7'h28;
  localparam logic [IW-1:0] P_RO_LO = 7'h39;
  localparam logic [IW-1:0] P_RO_HI = 7'h41;
  localparam logic [IW-1:0] P_FRATING = 7'h4e;
  localparam logic [IW-1:0] P_F_LO = 7'h53;
  localparam logic [IW-1:0] P_F_OPEN = 7'h56;
  localparam logic [IW-1:0] P_F_HI = 7'h5d;
  localparam logic [IW-1:0] P_RELOAD = 7'h5e;
  localparam logic [IW-1:0] P_PROT = 7'h5f;
  localparam logic [IW-1:0] P_FPERMIT = 7'h60;
  localparam logic [IW-1:0] P_VER = 7'h61;
  localparam logic [IW-1:0] R_STATUS = 7'h64;
  localparam logic [IW-1:0] R_FREQ = 7'h65;
  // field values
  localparam logic [DW-1:0] V_ZERO = 16'h0000;
  localparam logic [DW-1:0] V_ONE = 16'h0001;
  localparam logic [DW-1:0] V_TWO = 16'h0002;
  localparam logic [DW-1:0] V_RELOAD_ALL = 16'h00f9;
  localparam logic [DW-1:0] DISCH_PCT = 16'h0075;
  localparam logic [7:0] MIN_CARRIER_EXT = 8'h02;
  localparam logic [DW-1:0] PACK_DIV = 16'h000a;
  localparam logic [DW-1:0] TP_SCALE = 16'h0064;
  localparam logic [7:0] VOLT_FULL = 8'h64;
  // plain defaults: times in 0.1 s, frequencies in 0.1 Hz, carrier in kHz
  localparam logic [DW-1:0] DEF_RAMP = 16'h0032;
  localparam logic [DW-1:0] DEF_UPPER = 16'h0258;
  localparam logic [DW-1:0] DEF_MAXC = 16'h0008;
  localparam logic [DW-1:0] DEF_MINC = 16'h0002;
  localparam logic [DW-1:0] DEF_TRANS = 16'h00c8;
  // timing: one ms tick, one time unit is 100 ms
  localparam int CLK_HZ = 100000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_PER_DT = 100;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_STOP, ST_BRK_DROP, ST_BRK_INJ, ST_BLOCK} drv_state_t;

  function automatic logic [DW-1:0] def_val(input logic [IW-1:0] i);
    case (i)
      P_ACC, P_DEC: def_val = DEF_RAMP;
      P_UPPER: def_val = DEF_UPPER;
      P_MAXC: def_val = DEF_MAXC;
      P_MINC: def_val = DEF_MINC;
      P_TRANS: def_val = DEF_TRANS;
      default: def_val = V_ZERO;
    endcase
  endfunction

  function automatic logic is_factory(input logic [IW-1:0] i);
    is_factory = (i == P_FRATING) || (i >= P_F_LO && i <= P_F_HI && i != P_F_OPEN);
  endfunction

  function automatic logic is_ro(input logic [IW-1:0] i);
    is_ro = (i >= P_RO_LO && i <= P_RO_HI) || i == P_VER || i >= IW'(NUM_PARAM);
  endfunction
endpackage

/* src/drv_ramp_if.sv */
// carrier between the control block and its frequency ramp generator
`timescale 1ns/1ps
interface drv_ramp_if;
  logic tick;
  logic hold;
  logic zero;
  logic [15:0] target;
  logic [15:0] span;
  logic [15:0] t_acc;
  logic [15:0] t_dec;
  logic [15:0] freq;
  logic falling;
  modport ctrl (output tick, hold, zero, target, span, t_acc, t_dec, input freq, falling);
  modport ramp (input tick, hold, zero, target, span, t_acc, t_dec, output freq, falling);
endinterface

/* src/drv_ramp.sv */
// frequency ramp generator: span per ramp time, stepped by error accumulation
`timescale 1ns/1ps
module drv_ramp (
  input wire logic clk_i,
  input wire logic rst_i,
  drv_ramp_if.ramp rp
);
  logic [31:0] acc_q;
  logic [15:0] freq_q;
  logic falling_q;
  logic up;
  logic [31:0] den;
  logic step;
  // rate follows direction of travel; zero time means one step per clock
  assign up = freq_q < rp.target;
  assign den = (up ? {16'h0000, rp.t_acc} : {16'h0000, rp.t_dec}) * 32'(drv_pkg::MS_PER_DT);
  assign step = (freq_q != rp.target) && (acc_q >= den);

  // span added once per ms, one frequency unit taken per den
  always_ff @(posedge clk_i) begin
    if (rst_i || rp.zero) begin
      acc_q <= 32'h0;
      freq_q <= 16'h0;
    end else if (!rp.hold) begin
      if (freq_q == rp.target) begin
        acc_q <= 32'h0;
      end else begin
        acc_q <= acc_q + (rp.tick ? {16'h0000, rp.span} : 32'h0) - (step ? den : 32'h0);
      end
      if (step) begin
        freq_q <= up ? freq_q + 16'h1 : freq_q - 16'h1;
      end
    end
  end

  // decelerating flag for the bus discharge gate
  always_ff @(posedge clk_i) begin
    if (rst_i || rp.zero) begin
      falling_q <= 1'b0;
    end else begin
      falling_q <= !rp.hold && freq_q > rp.target;
    end
  end

  assign rp.freq = freq_q;
  assign rp.falling = falling_q;
endmodule // drv_ramp

/* src/drv_ctrl.sv */
// drive control: guarded parameter store, reload, ramp, braking, carrier, discharge, restart
// Function
// - level 1 refuses writes except main setpoint and protection level
// - level 0 accepts user parameters; factory class needs the write permit
// - level 0 with permit set accepts every parameter, factory class included; read-only ones stay refused
// - extended variant level 2 writes working copy only, reverted at reset
// - level 0 plus reload 1 then reset restores user parameters only
// - extended variant reload 249 at level 0 then reset restores everything
// - speed source 0 takes target frequency from working copy of main setpoint
// - ramp times are defined from zero to upper limit and back
// - below brake frequency hold frequency, drop voltage, then inject DC
// - injection lasts brake time minus brake delay, both from braking start
// - above transfer point use maximum carrier, otherwise minimum carrier
// - extended variant packs carrier and transfer point; minimum fixed 2 kHz
// - extended variant uses min carrier setting as serial byte gap
// - running frequency stays between lower and upper limits
// - target frequencies inside the resonance band are moved out
// - jog and presets carry own rates, also forced by assigned inputs
// - stop ramps down with coast 0, disables output at once with 1
// - reverse block 1 refuses reverse running, 0 allows both directions
// - discharge 1 gates on run, no alarm, bus above 117 percent, decel
// - discharge 2 gates on run, no alarm, bus above threshold
// - restart enable 1 restarts automatically once supply is normal again
// - voltage fault or block input keeps output off at least blank time
// - user and factory parameters live in a nonvolatile image
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module drv_ctrl #(
  parameter bit EXT_VARIANT = 1'b0,
  parameter int MS_CYC = drv_pkg::CLK_HZ / drv_pkg::MS_PER_S
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic factory_init_i,
  input wire logic alarm_reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic run_i,
  input wire logic rev_i,
  input wire logic inching_preset_i,
  input wire logic [1:0] preset_sel_i,
  input wire logic [3:0] rate_force_i,
  input wire logic base_block_i,
  input wire logic emergency_stop_input_i,
  input wire logic alarm_i,
  input wire logic undervolt_i,
  input wire logic overvoltage_event_i,
  input wire logic [15:0] dc_bus_level_i,
  input wire logic [15:0] speed_ref_i,
  output logic [15:0] out_freq_o,
  output logic [7:0] out_volt_o,
  output logic out_en_o,
  output logic dir_rev_o,
  output logic dc_inject_o,
  output logic [7:0] carrier_khz_o,
  output logic discharge_o,
  output logic [15:0] byte_gap_o,
  output logic nv_wr_o,
  output logic [6:0] nv_idx_o,
  output logic [15:0] nv_dat_o
);
  localparam int MSW = $clog2(MS_CYC + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYC - 1);
  localparam logic [7:0] DT_LAST = 8'(drv_pkg::MS_PER_DT - 1);

  logic [15:0] nv_q [drv_pkg::NUM_PARAM];
  logic [15:0] wk_q [drv_pkg::NUM_PARAM];
  logic ack_q;
  logic [31:0] dat_q;
  logic refused_q;
  logic nv_wr_q;
  logic [6:0] nv_idx_q;
  logic [15:0] nv_dat_q;
  logic [MSW-1:0] ms_cnt_q;
  logic [7:0] dt_cnt_q;
  logic ms_tick_q;
  logic dt_tick_q;
  drv_pkg::drv_state_t st_q;
  logic [15:0] brk_t_q;
  logic [15:0] blank_t_q;
  logic fault_q;
  logic dir_q;
  logic [7:0] volt_q;
  logic [7:0] carrier_q;
  logic disch_q;
  logic [15:0] gap_q;
  logic ctl_rst;
  logic req;
  logic [6:0] idx;
  logic mapped;
  logic wr_ok;
  logic ram_only;
  logic [15:0] wmerge;
  logic user_rl;
  logic all_rl;
  logic supply_bad;
  logic block_cause;
  logic run_ok;
  logic running;
  logic [15:0] sel_f;
  logic [15:0] lim_f;
  logic [15:0] t_acc;
  logic [15:0] t_dec;
  logic [15:0] pk_c;
  logic [15:0] pk_tp;

  drv_ramp_if rif ();

  drv_ramp u_ramp (
    .clk_i(clk_i),
    .rst_i(ctl_rst),
    .rp(rif.ramp)
  );

  // write permission by protection level, class and permit
  function automatic logic may_write(input logic [6:0] i, input logic [15:0] lvl, input logic [15:0] fp);
    if (drv_pkg::is_ro(i)) begin
      may_write = 1'b0;
    end else if (lvl == drv_pkg::V_ONE) begin
      may_write = (i == drv_pkg::P_MAIN) || (i == drv_pkg::P_PROT);
    end else if (lvl == drv_pkg::V_ZERO || (EXT_VARIANT && lvl == drv_pkg::V_TWO)) begin
      may_write = !drv_pkg::is_factory(i) || fp == drv_pkg::V_ONE;
    end else begin
      may_write = 1'b0;
    end
  endfunction

  // clamp to limits, then push out of the resonance band
  function automatic logic [15:0] limit(input logic [15:0] f, input logic [15:0] lo, input logic [15:0] hi,
                                        input logic [15:0] sk, input logic [15:0] bd);
    logic [16:0] r;
    r = (f > hi) ? {1'b0, hi} : ((f < lo) ? {1'b0, lo} : {1'b0, f});
    if (bd != 16'h0 && r + {1'b0, bd} >= {1'b0, sk} && r <= {1'b0, sk} + {1'b0, bd}) begin
      r = ({1'b0, sk} >= {1'b0, bd} + {1'b0, lo}) ? {1'b0, sk} - {1'b0, bd} : {1'b0, sk} + {1'b0, bd};
      if (r > {1'b0, hi}) begin
        r = {1'b0, hi};
      end
    end
    limit = r[15:0];
  endfunction

  assign ctl_rst = rst_i || alarm_reset_i;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign idx = wb_adr_i[8:2];
  assign mapped = wb_adr_i[31:9] == 23'h0;
  assign wr_ok = req && wb_we_i && mapped && may_write(idx, wk_q[drv_pkg::P_PROT], wk_q[drv_pkg::P_FPERMIT]);
  assign ram_only = EXT_VARIANT && wk_q[drv_pkg::P_PROT] == drv_pkg::V_TWO;
  assign wmerge = {wb_sel_i[1] ? wb_dat_i[15:8] : wk_q[idx][15:8], wb_sel_i[0] ? wb_dat_i[7:0] : wk_q[idx][7:0]};
  // reload decisions read the stored image, so working-only values never trigger one
  assign user_rl = nv_q[drv_pkg::P_PROT] == drv_pkg::V_ZERO && nv_q[drv_pkg::P_RELOAD] == drv_pkg::V_ONE;
  assign all_rl = EXT_VARIANT && nv_q[drv_pkg::P_PROT] == drv_pkg::V_ZERO
                  && nv_q[drv_pkg::P_RELOAD] == drv_pkg::V_RELOAD_ALL;

  // parameter store: nonvolatile image plus working copy
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      for (int i = 0; i < drv_pkg::NUM_PARAM; i++) begin
        if ((rst_i && factory_init_i) || all_rl || (user_rl && !drv_pkg::is_factory(7'(i)))) begin
          nv_q[i] <= drv_pkg::def_val(7'(i));
          wk_q[i] <= drv_pkg::def_val(7'(i));
        end else begin
          wk_q[i] <= nv_q[i];
        end
      end
    end else if (wr_ok) begin
      wk_q[idx] <= wmerge;
      if (!ram_only) begin
        nv_q[idx] <= wmerge;
      end
    end
  end

  // nonvolatile update request, only for accepted stored writes
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      nv_wr_q <= 1'b0;
      nv_idx_q <= 7'h00;
      nv_dat_q <= 16'h0000;
    end else begin
      nv_wr_q <= wr_ok && !ram_only;
      if (wr_ok && !ram_only) begin
        nv_idx_q <= idx;
        nv_dat_q <= wmerge;
      end
    end
  end

  // wishbone slave: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      refused_q <= 1'b0;
    end else begin
      ack_q <= req;
      if (req && wb_we_i) begin
        refused_q <= !wr_ok;
      end
      if (req && !wb_we_i) begin
        if (!mapped) begin
          dat_q <= 32'h0;
        end else if (idx < 7'(drv_pkg::NUM_PARAM)) begin
          dat_q <= {16'h0000, wk_q[idx]};
        end else if (idx == drv_pkg::R_STATUS) begin
          dat_q <= {24'h0, disch_q, dir_q, refused_q, fault_q, 1'b0, st_q};
        end else if (idx == drv_pkg::R_FREQ) begin
          dat_q <= {16'h0000, rif.freq};
        end else begin
          dat_q <= 32'h0;
        end
      end
    end
  end

  // ms and 0.1 s enables from one divider chain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_cnt_q <= '0;
      dt_cnt_q <= 8'h00;
      ms_tick_q <= 1'b0;
      dt_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= ms_cnt_q == MS_LAST;
      dt_tick_q <= ms_cnt_q == MS_LAST && dt_cnt_q == DT_LAST;
      ms_cnt_q <= (ms_cnt_q == MS_LAST) ? '0 : ms_cnt_q + 1'b1;
      if (ms_cnt_q == MS_LAST) begin
        dt_cnt_q <= (dt_cnt_q == DT_LAST) ? 8'h00 : dt_cnt_q + 8'h01;
      end
    end
  end

  // speed selection and per-command rates
  always_comb begin
    sel_f = (wk_q[drv_pkg::P_SRC] == drv_pkg::V_ZERO) ? wk_q[drv_pkg::P_MAIN] : speed_ref_i;
    t_acc = wk_q[drv_pkg::P_ACC];
    t_dec = wk_q[drv_pkg::P_DEC];
    if (inching_preset_i) begin
      sel_f = wk_q[drv_pkg::P_JOG];
    end else if (preset_sel_i != 2'b00) begin
      sel_f = wk_q[drv_pkg::P_PRESET_SPEED_ONE + 7'(3 * (preset_sel_i - 2'b01))];
    end
    if (inching_preset_i || rate_force_i[0]) begin
      t_acc = wk_q[drv_pkg::P_JOG_RATE];
      t_dec = wk_q[drv_pkg::P_JOG_RATE];
    end else begin
      for (int n = 1; n < 4; n++) begin
        if (preset_sel_i == 2'(n) || rate_force_i[n]) begin
          t_acc = wk_q[drv_pkg::P_PRESET_SPEED_ONE + 7'(3 * (n - 1) + 1)];
          t_dec = wk_q[drv_pkg::P_PRESET_SPEED_ONE + 7'(3 * (n - 1) + 2)];
        end
      end
    end
  end

  assign lim_f = limit(sel_f, wk_q[drv_pkg::P_LOWER], wk_q[drv_pkg::P_UPPER], wk_q[drv_pkg::P_SKIP],
                       wk_q[drv_pkg::P_BAND]);
  assign supply_bad = undervolt_i || overvoltage_event_i;
  assign block_cause = supply_bad || base_block_i;
  assign run_ok = run_i && !(rev_i && wk_q[drv_pkg::P_REV] == drv_pkg::V_ONE) && !fault_q && !alarm_i;
  assign running = st_q == drv_pkg::ST_RUN || st_q == drv_pkg::ST_STOP;

  assign rif.tick = ms_tick_q;
  assign rif.hold = st_q == drv_pkg::ST_BRK_DROP || st_q == drv_pkg::ST_BRK_INJ;
  assign rif.zero = st_q == drv_pkg::ST_IDLE || st_q == drv_pkg::ST_BLOCK;
  assign rif.target = (st_q == drv_pkg::ST_RUN) ? lim_f : 16'h0000;
  assign rif.span = wk_q[drv_pkg::P_UPPER];
  assign rif.t_acc = t_acc;
  assign rif.t_dec = t_dec;

  // run, stop, braking and blanking sequence
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      st_q <= drv_pkg::ST_IDLE;
      brk_t_q <= 16'h0;
      blank_t_q <= 16'h0;
      dir_q <= 1'b0;
    end else if (block_cause && st_q != drv_pkg::ST_BLOCK) begin
      st_q <= drv_pkg::ST_BLOCK;
      blank_t_q <= 16'h0;
    end else begin
      unique case (st_q)
        drv_pkg::ST_IDLE: begin
          if (run_ok) begin
            st_q <= drv_pkg::ST_RUN;
            dir_q <= rev_i;
          end
        end
        drv_pkg::ST_RUN: begin
          if (!run_ok) begin
            st_q <= (wk_q[drv_pkg::P_COAST] == drv_pkg::V_ONE) ? drv_pkg::ST_IDLE : drv_pkg::ST_STOP;
          end
        end
        drv_pkg::ST_STOP: begin
          brk_t_q <= 16'h0;
          if (run_ok && !emergency_stop_input_i) begin
            st_q <= drv_pkg::ST_RUN;
          end else if (wk_q[drv_pkg::P_BRK_TIME] != 16'h0
                       && (emergency_stop_input_i || rif.freq < wk_q[drv_pkg::P_BRK_FREQ])) begin
            st_q <= drv_pkg::ST_BRK_DROP;
          end else if (rif.freq == 16'h0) begin
            st_q <= drv_pkg::ST_IDLE;
          end
        end
        drv_pkg::ST_BRK_DROP: begin
          if (brk_t_q >= wk_q[drv_pkg::P_BRK_DLY]) begin
            st_q <= drv_pkg::ST_BRK_INJ;
          end else if (dt_tick_q) begin
            brk_t_q <= brk_t_q + 16'h1;
          end
        end
        drv_pkg::ST_BRK_INJ: begin
          if (brk_t_q >= wk_q[drv_pkg::P_BRK_TIME]) begin
            st_q <= drv_pkg::ST_IDLE;
          end else if (dt_tick_q) begin
            brk_t_q <= brk_t_q + 16'h1;
          end
        end
        drv_pkg::ST_BLOCK: begin
          // count restarts while any cause stays, so blanking runs from its end
          if (block_cause) begin
            blank_t_q <= 16'h0;
          end else if (blank_t_q >= wk_q[drv_pkg::P_BLANK]) begin
            st_q <= drv_pkg::ST_IDLE;
          end else if (dt_tick_q) begin
            blank_t_q <= blank_t_q + 16'h1;
          end
        end
      endcase
    end
  end

  // supply fault latch: automatic restart only when enabled
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      fault_q <= 1'b0;
    end else if (supply_bad) begin
      fault_q <= 1'b1;
    end else if (wk_q[drv_pkg::P_RESTART] == drv_pkg::V_ONE && st_q != drv_pkg::ST_BLOCK) begin
      fault_q <= 1'b0;
    end
  end

  // output voltage: full while running, stepped down to brake level
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      volt_q <= 8'h00;
    end else if (running) begin
      volt_q <= drv_pkg::VOLT_FULL;
    end else if (st_q == drv_pkg::ST_BRK_DROP) begin
      if (ms_tick_q && volt_q > wk_q[drv_pkg::P_BRK_VOLT][7:0]) begin
        volt_q <= volt_q - 8'h01;
      end
    end else if (st_q == drv_pkg::ST_BRK_INJ) begin
      volt_q <= wk_q[drv_pkg::P_BRK_VOLT][7:0];
    end else begin
      volt_q <= 8'h00;
    end
  end

  // carrier selection; packed form split by tens
  assign pk_c = wk_q[drv_pkg::P_MAXC] / drv_pkg::PACK_DIV;
  assign pk_tp = 16'((wk_q[drv_pkg::P_MAXC] % drv_pkg::PACK_DIV) * drv_pkg::TP_SCALE);
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      carrier_q <= 8'h00;
    end else if (EXT_VARIANT) begin
      carrier_q <= (rif.freq > pk_tp) ? pk_c[7:0] : drv_pkg::MIN_CARRIER_EXT;
    end else begin
      carrier_q <= (rif.freq > wk_q[drv_pkg::P_TRANS]) ? wk_q[drv_pkg::P_MAXC][7:0]
                                                        : wk_q[drv_pkg::P_MINC][7:0];
    end
  end

  // discharge gate and serial byte gap setting
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      disch_q <= 1'b0;
      gap_q <= 16'h0;
    end else begin
      disch_q <= running && !alarm_i && dc_bus_level_i > drv_pkg::DISCH_PCT
                 && ((wk_q[drv_pkg::P_DISCH] == drv_pkg::V_ONE && rif.falling)
                     || wk_q[drv_pkg::P_DISCH] == drv_pkg::V_TWO);
      gap_q <= EXT_VARIANT ? wk_q[drv_pkg::P_MINC] : 16'h0;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      out_freq_o <= 16'h0;
      out_en_o <= 1'b0;
      dc_inject_o <= 1'b0;
    end else begin
      out_freq_o <= rif.freq;
      out_en_o <= running || rif.hold;
      dc_inject_o <= st_q == drv_pkg::ST_BRK_INJ;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign out_volt_o = volt_q;
  assign dir_rev_o = dir_q;
  assign carrier_khz_o = carrier_q;
  assign discharge_o = disch_q;
  assign byte_gap_o = gap_q;
  assign nv_wr_o = nv_wr_q;
  assign nv_idx_o = nv_idx_q;
  assign nv_dat_o = nv_dat_q;
endmodule // drv_ctrl

/* bench/dpg_bus_host.sv */
// wishbone master model of the panel or serial host
`timescale 1ns/1ps
module dpg_bus_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [31:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o
);
  // idle bus from time zero
  initial {cyc_o, stb_o, we_o, adr_o, dat_o, sel_o} = '0;
  // one classic cycle held until ack is sampled; ok stays low on no answer
  task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    ok = 1'b0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= {16'h0000, d};
    sel_o <= 4'h3;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_i);
      ok = (ack_i === 1'b1);
    end
    q = dat_i[15:0];
    // released address and data lines must not keep the old value
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~{16'h0000, d};
    @(posedge clk_i);
  endtask
endmodule // dpg_bus_host

/* bench/dpg_checker.sv */
// port-level assertions for the drive control block
`timescale 1ns/1ps
module dpg_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic alarm_i,
  input wire logic base_block_i,
  input wire logic undervolt_i,
  input wire logic [15:0] dc_bus_level_i,
  input wire logic out_en_o,
  input wire logic discharge_o,
  input wire logic nv_wr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // request first seen, then a single-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK: assert property (s_req |=> s_ans) else $error("ack timing");
  AST_NO_ACK: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  // read data only moves on the edge that takes a read
  AST_DAT_HOLD: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data moved");
  AST_RST: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !out_en_o && !discharge_o && !nv_wr_o)
    else $error("output active after reset");
  AST_DISCH_ALARM: assert property (alarm_i [*3] |=> !discharge_o) else $error("discharge on alarm");
  AST_DISCH_BUS: assert property ((dc_bus_level_i <= 16'h0075) [*3] |=> !discharge_o)
    else $error("discharge at low bus");
  // same cycle: both outputs follow the run state one edge late, so a start must not look like a breach
  AST_DISCH_RUN: assert property ((!out_en_o) [*3] |-> !discharge_o) else $error("discharge when stopped");
  AST_BLOCK: assert property (base_block_i [*3] |=> !out_en_o) else $error("output on in block");
  AST_UV: assert property (undervolt_i [*3] |=> !out_en_o) else $error("output on in fault");
endmodule // dpg_checker

/* bench/test_drive_param_guard_and_stop_ctrl.sv */
// self-checking bench for the drive control block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t %h %h", $time, a, b); end end
module test_drive_param_guard_and_stop_ctrl;
  typedef struct packed {logic [15:0] p; logic [15:0] f; logic [6:0] i; logic [15:0] d; logic [15:0] e;} dpg_row_t;
  // level, permit, index, written value, expected readback
  dpg_row_t rows [5] = '{'{16'h0, 16'h0, 7'h01, 16'h77, 16'h77}, '{16'h0, 16'h0, 7'h4e, 16'h55, 16'h0},
    '{16'h0, 16'h1, 7'h4e, 16'h55, 16'h55}, '{16'h1, 16'h0, 7'h01, 16'h11, 16'h77},
    '{16'h1, 16'h0, 7'h00, 16'h123, 16'h123}};
  logic clk_i, rst_i, fi, ar, run, rev, bb, al, uv, es, cyc, stb, we, ack, en, dis, ok;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  logic [15:0] dc_bus_level, freq, q;
  logic [7:0] car;
  int n_fail = 0;
  int cmp_count = 0;
  int n;
  // short millisecond so ramps fit the run
  drv_ctrl #(.MS_CYC(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .factory_init_i(fi), .alarm_reset_i(ar),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .run_i(run), .rev_i(rev), .inching_preset_i(1'b0), .preset_sel_i(2'h0),
    .rate_force_i(4'h0), .base_block_i(bb), .emergency_stop_input_i(es), .alarm_i(al), .undervolt_i(uv),
    .overvoltage_event_i(uv), .dc_bus_level_i(dc_bus_level), .speed_ref_i(16'h0000), .out_freq_o(freq), .out_volt_o(),
    .out_en_o(en), .dir_rev_o(), .dc_inject_o(), .carrier_khz_o(car), .discharge_o(dis), .byte_gap_o(),
    .nv_wr_o(), .nv_idx_o(), .nv_dat_o());
  dpg_bus_host i_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .dat_o(wdat), .sel_o(sel));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one register access; a missing answer ends the run
  task automatic acc(input logic w, input logic [6:0] i, input logic [15:0] d);
    i_host.xfer(w, {23'h0, i, 2'h0}, d, q, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      test_done();
    end
  endtask
  // main sequence
  initial begin
    {rst_i, fi, ar, run, rev, bb, al, uv, es, dc_bus_level} = {2'b11, 23'h0};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    fi <= 1'b0;
    foreach (rows[k]) begin
      acc(1'b1, 7'h5f, 16'h0);
      acc(1'b1, 7'h60, rows[k].f);
      acc(1'b1, 7'h5f, rows[k].p);
      acc(1'b1, rows[k].i, rows[k].d);
      acc(1'b0, rows[k].i, 16'h0);
      `CHK(q, rows[k].e)
    end
    i_host.xfer(1'b0, 32'h0000_0200, 16'h0, q, ok);
    `CHK({ok, q}, 17'h10000)
    // reload through hardware reset, then through alarm reset
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, 7'h5f, 16'h0);
      acc(1'b1, 7'h01, 16'h77);
      acc(1'b1, 7'h5e, 16'h1);
      rst_i <= (k == 0);
      ar <= (k == 1);
      repeat (2) @(posedge clk_i);
      {rst_i, ar} <= 2'b00;
      acc(1'b0, 7'h01, 16'h0);
      `CHK(q, 16'h0032)
      acc(1'b0, 7'h4e, 16'h0);
      `CHK(q, 16'h0055)
    end
    acc(1'b1, 7'h00, 16'h123);
    acc(1'b1, 7'h01, 16'h1);
    run <= 1'b1;
    dc_bus_level <= 16'h0080;
    for (n = 0; n < 2000 && freq !== 16'h0123; n++) begin
      @(posedge clk_i);
    end
    `CHK(n >= 400 && n <= 600, 1'b1)
    if (n == 2000) test_done();
    `CHK({en, car, dis}, {1'b1, 8'h08, 1'b0})
    // discharge: always-on mode, bus at threshold, then decel-only mode steady and falling
    acc(1'b1, 7'h21, 16'h2);
    `CHK(dis, 1'b1)
    dc_bus_level <= 16'h0075;
    repeat (4) @(posedge clk_i);
    `CHK(dis, 1'b0)
    dc_bus_level <= 16'h0080;
    acc(1'b1, 7'h21, 16'h1);
    `CHK(dis, 1'b0)
    acc(1'b1, 7'h00, 16'h100);
    @(posedge clk_i);
    `CHK(dis, 1'b1)
    acc(1'b1, 7'h1e, 16'h1);
    run <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(en, 1'b0)
    acc(1'b1, 7'h1f, 16'h1);
    rev <= 1'b1;
    run <= 1'b1;
    repeat (20) @(posedge clk_i);
    `CHK(en, 1'b0)
    rev <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK(en, 1'b1)
    // emergency stop on a ramped stop: zero brake delay goes straight to injection, output held on
    acc(1'b1, 7'h1e, 16'h0);
    acc(1'b1, 7'h07, 16'h2);
    {es, run} <= 2'b10;
    repeat (2) @(posedge clk_i);
    acc(1'b0, 7'h64, 16'h0);
    `CHK(q[2:0], 3'h4)
    `CHK(en, 1'b1)
    {bb, al, uv} <= 3'b111;
    repeat (4) @(posedge clk_i);
    `CHK(en, 1'b0)
    test_done();
  end
endmodule // test_drive_param_guard_and_stop_ctrl
bind drv_ctrl dpg_checker i_chk (.*);
